// *** logic/pin_sync.sv ***
`timescale 1ns/1ps
`include "quint_latch_cfg.svh"
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  // A bit changes only once the second and third stages agree.
  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  assign o_level = level;
endmodule

// *** logic/quint_latch.sv ***
`timescale 1ns/1ps
`include "quint_latch_cfg.svh"
module quint_latch (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire quint_latch_pkg::latch_word_type i_data,
  input wire quint_latch_pkg::latch_ctrl_type i_ctrl,
  output quint_latch_pkg::latch_word_type o_q
);
  // Five independent data latches share one combined clock and one reset.
  // The latch itself is modelled as a small state machine on the system clock.
  // Every pin passes a three-stage synchroniser and an agree stage.
  // A change on a pin therefore reaches the output four cycles after it is sampled.
  // A pin pulse shorter than about two clock cycles may never be seen at all.
  // Data and control pass pipelines of equal depth, so a word that changes together with
  // the clock inputs is seen together with them, and that word is the one captured.
  // While the combined clock is low the reset pin is ignored entirely.

  // Open passes the data inputs through; held keeps the captured word.
  typedef enum logic {
    LATCH_OPEN = 1'b0,
    LATCH_HELD = 1'b1
  } latch_state_type;

  // Reset release chain and the internal reset it yields.
  logic [`RESET_SYNC_DEPTH-1:0] rst_sync;
  logic [`RESET_SYNC_DEPTH-1:0] next_rst_sync;
  logic nrst;

  // Synchronised pin levels.
  quint_latch_pkg::latch_word_type data_s;
  quint_latch_pkg::latch_ctrl_type ctrl_s;

  // Decoded clock and reset conditions.
  logic combined_clock;
  logic clear_now;
  logic clock_rise;
  logic clock_fall;

  // Latch state, captured word and output word.
  latch_state_type state;
  latch_state_type next_state;
  quint_latch_pkg::latch_word_type captured;
  quint_latch_pkg::latch_word_type next_captured;
  quint_latch_pkg::latch_word_type q;
  quint_latch_pkg::latch_word_type next_q;

  // Either clock input high closes every latch.
  function automatic logic clock_level(
    input quint_latch_pkg::latch_ctrl_type ctrl
  );
    clock_level = ctrl.clock_in_a | ctrl.clock_in_b;
  endfunction

  // Reset only counts while the combined clock is high.
  function automatic logic clear_level(
    input quint_latch_pkg::latch_ctrl_type ctrl
  );
    clear_level = clock_level(ctrl) & ctrl.reset;
  endfunction

  // A closed latch shows its stored word unless reset clears it.
  function automatic quint_latch_pkg::latch_word_type closed_word(
    input quint_latch_pkg::latch_word_type stored,
    input logic clear
  );
    if (clear) begin
      closed_word = `LATCH_CLEAR;
    end else begin
      closed_word = stored;
    end
  endfunction

  // Reset is taken at once but released through a short chain,
  // so that all registers leave reset on the same clock edge.
  always_comb begin
    next_rst_sync = {rst_sync[`RESET_SYNC_DEPTH-2:0], 1'b1};
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync <= `RESET_SYNC_CLEAR;
    end else begin
      rst_sync <= next_rst_sync;
    end
  end

  assign nrst = rst_sync[`RESET_SYNC_DEPTH-1];

  pin_sync #(
    .WIDTH(`LATCH_COUNT)
  ) u_data_sync (
    .i_clk(i_clk),
    .i_nrst(nrst),
    .i_pin(i_data),
    .o_level(data_s)
  );

  pin_sync #(
    .WIDTH($bits(quint_latch_pkg::latch_ctrl_type))
  ) u_ctrl_sync (
    .i_clk(i_clk),
    .i_nrst(nrst),
    .i_pin(i_ctrl),
    .o_level(ctrl_s)
  );

  // Decode of the synchronised control pins against the present latch state.
  always_comb begin
    combined_clock = clock_level(ctrl_s);
    clear_now = clear_level(ctrl_s);
    clock_rise = 1'b0;
    clock_fall = 1'b0;
    case (state)
      LATCH_OPEN: begin
        clock_rise = combined_clock;
      end
      LATCH_HELD: begin
        clock_fall = !combined_clock;
      end
      default: begin
        clock_rise = 1'b0;
        clock_fall = 1'b0;
      end
    endcase
  end

  // The state follows the combined clock: high closes the latch, low opens it.
  always_comb begin
    next_state = state;
    case (state)
      LATCH_OPEN: begin
        if (clock_rise) begin
          next_state = LATCH_HELD;
        end
      end
      LATCH_HELD: begin
        if (clock_fall) begin
          next_state = LATCH_OPEN;
        end
      end
      default: begin
        next_state = LATCH_OPEN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge nrst) begin
    if (!nrst) begin
      state <= LATCH_OPEN;
    end else begin
      state <= next_state;
    end
  end

  // The captured word is what a held latch keeps.
  // Reset while held clears it, and it stays clear until the next closing of the latch captures new data.
  always_comb begin
    next_captured = captured;
    case (state)
      LATCH_OPEN: begin
        if (clock_rise) begin
          next_captured = closed_word(data_s, clear_now);
        end
      end
      LATCH_HELD: begin
        if (!clock_fall) begin
          next_captured = closed_word(captured, clear_now);
        end
      end
      default: begin
        next_captured = `LATCH_CLEAR;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge nrst) begin
    if (!nrst) begin
      captured <= `LATCH_CLEAR;
    end else begin
      captured <= next_captured;
    end
  end

  // An open latch passes its data; a closing or closed latch shows the captured word.
  // Reset has no path to the output while the latch is open.
  always_comb begin
    next_q = q;
    case (state)
      LATCH_OPEN: begin
        if (clock_rise) begin
          next_q = next_captured;
        end else begin
          next_q = data_s;
        end
      end
      LATCH_HELD: begin
        if (clock_fall) begin
          next_q = data_s;
        end else begin
          next_q = next_captured;
        end
      end
      default: begin
        next_q = `LATCH_CLEAR;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge nrst) begin
    if (!nrst) begin
      q <= `LATCH_CLEAR;
    end else begin
      q <= next_q;
    end
  end

  // The output comes straight from a register, so it never glitches.
  assign o_q = q;
endmodule

// *** logic/quint_latch_cfg.svh ***
// Overview of operation
// - Five one-bit data latches share one reset input and one combined clock.
// - The combined clock is the OR of the two clock inputs, so either one high puts every latch in its clock-high state.
// - While the combined clock is low each output follows its data input and reset has no effect.
// - On a falling combined clock each latch opens and starts passing its data input.
// - On a rising combined clock each latch captures the data present at that moment.
// - While the combined clock is high and reset is low each output keeps its stored value and ignores data.
// - Reset acts only while the combined clock is high, and then drives all five outputs low.
`ifndef QUINT_LATCH_CFG_SVH
`define QUINT_LATCH_CFG_SVH
`define LATCH_COUNT 5
`define LATCH_CLEAR 5'h00
`define RESET_SYNC_DEPTH 2
`define RESET_SYNC_CLEAR 2'h0
`endif

// *** logic/quint_latch_pkg.sv ***
`include "quint_latch_cfg.svh"
package quint_latch_pkg;
  typedef logic [`LATCH_COUNT-1:0] latch_word_type;
  typedef struct packed {
    logic clock_in_a;
    logic clock_in_b;
    logic reset;
  } latch_ctrl_type;
endpackage

// *** tb/latch_source.sv ***
`timescale 1ns/1ps
module latch_source (
  input wire logic i_clk,
  input wire logic [7:0] i_cmd,
  output logic [7:0] o_pins
);
  always @(posedge i_clk) o_pins <= i_cmd;
endmodule

// *** tb/quint_latch_assertions.sv ***
`timescale 1ns/1ps
module latch_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire quint_latch_pkg::latch_word_type i_data,
  input wire quint_latch_pkg::latch_ctrl_type i_ctrl,
  input wire quint_latch_pkg::latch_word_type o_q
);
  wire logic hi = i_ctrl.clock_in_a | i_ctrl.clock_in_b;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  sequence s_settled_open;
    (!hi && $stable(i_data))[*8];
  endsequence
  sequence s_closed_run;
    (hi && !i_ctrl.reset)[*8];
  endsequence
  sequence s_open_change;
    $changed(i_data) && $stable(i_ctrl) && !hi;
  endsequence
  sequence s_open_quiet;
    (!hi && $stable(i_data) && $stable(i_ctrl))[*6];
  endsequence
  property p_capture;
    s_settled_open ##1 s_closed_run |-> o_q == $past(i_data, 7);
  endproperty
  a_capture: assert property (p_capture) else $error("capture");
  property p_follow;
    s_open_change ##1 s_open_quiet |-> o_q == i_data;
  endproperty
  a_follow: assert property (p_follow) else $error("follow latency");
  property p_rst_clear;
    disable iff (1'b0) !i_nrst |-> o_q == 5'h00;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset clear");
  property p_open;
    $stable({i_data, i_ctrl})[*8] ##0 !hi |-> o_q == i_data;
  endproperty
  a_open: assert property (p_open) else $error("open");
  property p_hold;
    s_closed_run |=> $stable(o_q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_clr;
    (hi && i_ctrl.reset)[*8] |-> o_q == 5'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
endmodule
bind quint_latch latch_chk chk (.i_clk, .i_nrst, .i_data, .i_ctrl, .o_q);

// *** tb/test_quint_latch.sv ***
`timescale 1ns/1ps
module test_quint_latch;
  logic i_clk = 1'b0;
  logic i_nrst;
  logic [7:0] cmd = 8'h00;
  logic [7:0] pins;
  logic [4:0] q;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  latch_source src (.i_clk(i_clk), .i_cmd(cmd), .o_pins(pins));
  quint_latch DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_data(pins[7:3]), .i_ctrl(pins[2:0]), .o_q(q));
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 900) begin
      fails++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task compare_q(input logic [4:0] e);
    total_checks++;
    if (q !== e) begin
      fails++;
      $display("FAIL o_q expected %h seen %h", e, q);
    end
  endtask
  // The command byte is data, then clock_in_a, clock_in_b and reset.
  task step(input logic [7:0] c, input logic [4:0] e);
    cmd <= c;
    repeat (9) @(posedge i_clk);
    compare_q(e);
  endtask
  task test_follow();
    step(8'hA9, 5'h15);
    step(8'h50, 5'h0A);
    $display("follow test done");
  endtask
  task test_capture();
    step(8'hB0, 5'h16);
    step(8'hB4, 5'h16);
    step(8'h4C, 5'h16);
    $display("capture test done");
  endtask
  task test_reset();
    step(8'h4D, 5'h00);
    step(8'h4C, 5'h00);
    step(8'h48, 5'h09);
    $display("reset test done");
  endtask
  task test_second_clock();
    step(8'hF8, 5'h1F);
    step(8'hFA, 5'h1F);
    step(8'h02, 5'h1F);
    step(8'h03, 5'h00);
    $display("second clock test done");
  endtask
  task test_async_reset();
    step(8'hF8, 5'h1F);
    i_nrst <= 1'b0;
    @(posedge i_clk);
    compare_q(5'h00);
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (12) @(posedge i_clk);
    compare_q(5'h1F);
    $display("async reset test done");
  endtask
  initial begin
    i_nrst <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    test_follow();
    test_capture();
    test_reset();
    test_second_clock();
    test_async_reset();
    report_and_stop();
  end
endmodule
